//--- rtl/eam_pkg.sv
package eam_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_HIST   = 8'h08;
	localparam logic [7:0] ADDR_ERRSEC = 8'h0C;
	localparam logic [7:0] ADDR_INJECT = 8'h10;

	// Control register fields
	localparam int CTRL_W         = 9;
	localparam int C_CAS_EN       = 0;
	localparam int C_CRC4_EN      = 1;
	localparam int C_EXTERNAL_DTE_CLOCK_SELECT      = 2;
	localparam int C_ONES_DENS    = 3;
	localparam int C_PATT_ON      = 4;
	localparam int C_LOOP_UP      = 5;
	localparam int C_REMOTE_LOOP  = 6;
	localparam int C_LINE_LOOP    = 7;
	localparam int C_PORT_LOOP    = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

	// Status register fields
	localparam int ST_W           = 23;
	localparam int S_NET_LOF      = 0;
	localparam int S_NET_MF_LOSS  = 1;
	localparam int S_NET_CRC_LOSS = 2;
	localparam int S_NET_FAR      = 3;
	localparam int S_NET_FAR_MF   = 4;
	localparam int S_NET_AIS      = 5;
	localparam int S_NET_TS16_AIS = 6;
	localparam int S_LOOP1_DOWN   = 7;
	localparam int S_LOOP2_DOWN   = 8;
	localparam int S_DP_SLIP      = 9;
	localparam int S_DP_PLL       = 10;
	localparam int S_DP_ZEROS     = 11;
	localparam int S_DP_FIFO      = 12;
	localparam int S_DP_NO_EXT    = 13;
	localparam int S_DROP_LOF     = 14;
	localparam int S_DROP_MF_LOSS = 15;
	localparam int S_DROP_CRC     = 16;
	localparam int S_DROP_LOS     = 17;
	localparam int S_DROP_FAR     = 18;
	localparam int S_DROP_FAR_MF  = 19;
	localparam int S_DROP_AIS     = 20;
	localparam int S_DROP_BER     = 21;
	localparam int S_DROP_SLIP    = 22;

	// History register field
	localparam int H_DROP_SLIP    = 0;

	// Port indices for the two framed sides
	localparam int P_NET          = 0;
	localparam int P_DROP         = 1;

	// Far-end multiframe alarm needs this many multiframes in a row
	localparam logic [1:0] FAR_MF_COUNT = 2'h3;

	// Error ratio window and allowed errors in it
	localparam logic [9:0] BER_WIN_BITS = 10'h3E8;
	localparam logic [9:0] BER_MAX_ERR  = 10'h001;

	// Zero run on the outgoing stream that raises the zeros alarm
	localparam logic [4:0] ZERO_RUN_BITS = 5'h10;

	// Timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int ONE_SEC_NS     = 1000000000;
	localparam int ONE_SEC_CYC    = ONE_SEC_NS / CLK_PERIOD_NS;
	localparam int EXT_TO_NS      = 20000;
	localparam int EXT_TO_CYC     = EXT_TO_NS / CLK_PERIOD_NS;

	// Pattern generators
	localparam logic [8:0] PRBS9_SEED = 9'h1FF;
	localparam logic [6:0] PRBS7_SEED = 7'h7F;

endpackage : eam_pkg

//--- rtl/eam_alarm.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
// Behaviour
// - Network frame loss: send remote alarm, drop AIS
// - Network multiframe loss under CAS: MF alarm, TS16 AIS
// - Flag received remote alarm on either port
// - Far-end MF alarm after three consecutive multiframes
// - Network AIS: flag it, send drop AIS
// - Network TS16 AIS: flag, MF alarm, TS16 AIS
// - Network CRC-4 loss: remote alarm, drop AIS
// - Drop frame loss: set drop remote alarm bit
// - Drop multiframe loss: drop MF alarm, TS16 AIS
// - Drop CRC-4 loss: drop remote alarm and AIS
// - Drop signal loss and AIS alarms
// - Drop slip flag, kept in history register
// - Drop error ratio above one per thousand
// - Data port clock slip and PLL alarms
// - Zeros alarm on all-zero outgoing data
// - Data port FIFO alarm
// - Missing external clock only when selected
// - Loop up loops both data port sides
// - Remote loop up sends V.54 pattern unless test pattern is also on
// - Test pattern on sends 511 pattern
// - Report each line loop down
// - Drop line and port loopback control
// - Force ones after one second of zeros
// - 511 errored seconds and error injection
module eam_alarm #(
	parameter int SEC_CYC = eam_pkg::ONE_SEC_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Framer conditions, index 0 network side, 1 drop port
	input  wire logic [1:0]  frm_lof,
	input  wire logic [1:0]  frm_mf_loss,
	input  wire logic [1:0]  frm_crc_loss,
	input  wire logic [1:0]  frm_nfas_bit3,
	input  wire logic [1:0]  frm_mf_strobe,
	input  wire logic [1:0]  frm_ts16_bit6,
	input  wire logic [1:0]  frm_ais_det,
	input  wire logic        net_ts16_ais_det,
	input  wire logic        loop1_present,
	input  wire logic        loop2_present,
	// Drop port receive conditions
	input  wire logic        drop_los_det,
	input  wire logic        drop_slip,
	input  wire logic        drop_bit_strobe,
	input  wire logic        drop_bit_error,
	// Channelized data port conditions
	input  wire logic        dp_clock_slip,
	input  wire logic        dp_pll_unlocked,
	input  wire logic        dp_fifo_error,
	input  wire logic        dte_external_dte_clock_select_edge,
	// Channelized data port bit streams
	input  wire logic        net_tx_strobe,
	input  wire logic        dte_tx_bit,
	input  wire logic        net_rx_strobe,
	input  wire logic        net_rx_bit,
	output logic             net_tx_bit,
	// Alarm signalling toward network and drop port
	output logic             net_tx_remote_alarm,
	output logic             net_tx_mf_alarm,
	output logic             drop_tx_ais,
	output logic             drop_tx_ts16_ais,
	output logic             drop_tx_remote_alarm,
	output logic             drop_tx_mf_alarm,
	// Loopback controls
	output logic             dp_loop_net,
	output logic             dp_loop_dte,
	output logic             drop_line_loop,
	output logic             drop_port_loop
);
	import eam_pkg::*;

	typedef struct packed {
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic [CTRL_W-1:0] ctrl;
		logic              hist;
		logic [ST_W-1:0]   status;
		logic [1:0][1:0]   mf_cnt;
		logic [9:0]        ber_bits;
		logic [9:0]        ber_err;
		logic [7:0]        ext_cnt;
		logic [23:0]       zero_cyc;
		logic              force_ones;
		logic [4:0]        zero_run;
		logic [8:0]        prbs9;
		logic [6:0]        prbs7;
		logic              inject;
		logic [8:0]        rx_hist;
		logic [23:0]       sec_cnt;
		logic              sec_err;
		logic [15:0]       errsec;
		logic              tx_bit;
		logic              net_remote;
		logic              net_mf;
		logic              d_ais;
		logic              d_ts16;
		logic              d_remote;
		logic              d_mf;
		logic              loop_net;
		logic              loop_dte;
		logic              line_loop;
		logic              port_loop;
	} eam_state_t;

	typedef enum logic [1:0] {
		SRC_DTE,
		SRC_V54,
		SRC_PRBS
	} eam_src_t;

	localparam logic [23:0] SEC_LAST = 24'(SEC_CYC - 1);
	localparam logic [7:0]  EXT_LAST = 8'(EXT_TO_CYC - 1);

	logic       rst_meta;
	logic       rst_n;
	eam_state_t s;
	eam_state_t next_s;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
		addr_hit = (a == reg_addr);
	endfunction : addr_hit

	function automatic logic [8:0] prbs9_step(input logic [8:0] r);
		prbs9_step = {r[7:0], r[8] ^ r[4]};
	endfunction : prbs9_step

	function automatic logic [6:0] prbs7_step(input logic [6:0] r);
		prbs7_step = {r[5:0], r[6] ^ r[3]};
	endfunction : prbs7_step

	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = addr_hit(a, ADDR_CTRL) || addr_hit(a, ADDR_STATUS)
			|| addr_hit(a, ADDR_HIST) || addr_hit(a, ADDR_ERRSEC)
			|| addr_hit(a, ADDR_INJECT);
	endfunction : reg_mapped

	function automatic eam_src_t tx_source(input logic [CTRL_W-1:0] c);
		if (c[C_PATT_ON])
			tx_source = SRC_PRBS;
		else if (c[C_REMOTE_LOOP])
			tx_source = SRC_V54;
		else
			tx_source = SRC_DTE;
	endfunction : tx_source

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	always_comb begin
		logic       cas;
		logic       crc;
		logic       wr;
		logic       rd_ok;
		logic [8:0] pat;
		logic       gen_bit;
		logic       acc;
		logic       rx_err;
		eam_src_t   src;
		next_s = s;
		cas    = s.ctrl[C_CAS_EN];
		crc    = s.ctrl[C_CRC4_EN];
		wr     = psel && penable && pwrite && s.pready;
		rd_ok  = 1'b0;
		pat    = 9'h000;
		gen_bit = 1'b0;
		acc     = psel && penable && !s.pready;
		rx_err  = 1'b0;
		src     = tx_source(s.ctrl);

		// APB access, answered one cycle into the access phase
		next_s.pready = acc;
		if (acc) begin
			next_s.prdata  = 32'h0000_0000;
			next_s.pslverr = 1'b0;
			rd_ok = reg_mapped(paddr);
			if (!rd_ok)
				next_s.pslverr = 1'b1;
			else if (!pwrite) begin
				if (addr_hit(paddr, ADDR_CTRL))
					next_s.prdata = {{(32-CTRL_W){1'b0}}, s.ctrl};
				else if (addr_hit(paddr, ADDR_STATUS))
					next_s.prdata = {{(32-ST_W){1'b0}}, s.status};
				else if (addr_hit(paddr, ADDR_HIST))
					next_s.prdata = {31'h0000_0000, s.hist};
				else if (addr_hit(paddr, ADDR_ERRSEC))
					next_s.prdata = {16'h0000, s.errsec};
			end
		end else begin
			next_s.pslverr = 1'b0;
			next_s.prdata  = 32'h0000_0000;
		end
		if (wr && addr_hit(paddr, ADDR_CTRL))
			next_s.ctrl = pwdata[CTRL_W-1:0];
		if (wr && addr_hit(paddr, ADDR_HIST) && pwdata[H_DROP_SLIP])
			next_s.hist = 1'b0;
		if (drop_slip)
			next_s.hist = 1'b1;

		// Far-end multiframe alarm counting per port
		for (int p = 0; p < 2; p++) begin
			if (frm_mf_strobe[p]) begin
				if (!frm_ts16_bit6[p])
					next_s.mf_cnt[p] = 2'h0;
				else if (s.mf_cnt[p] != FAR_MF_COUNT)
					next_s.mf_cnt[p] = s.mf_cnt[p] + 2'h1;
			end
		end

		// Drop error ratio over a fixed bit window
		if (drop_bit_strobe) begin
			if (s.ber_bits == BER_WIN_BITS - 10'h001) begin
				next_s.ber_bits = 10'h000;
				next_s.ber_err  = 10'h000;
				next_s.status[S_DROP_BER] = (s.ber_err + 10'(drop_bit_error)) > BER_MAX_ERR;
			end else begin
				next_s.ber_bits = s.ber_bits + 10'h001;
				next_s.ber_err  = s.ber_err + 10'(drop_bit_error);
			end
		end

		// External clock watchdog
		if (dte_external_dte_clock_select_edge)
			next_s.ext_cnt = 8'h00;
		else if (s.ext_cnt != EXT_LAST)
			next_s.ext_cnt = s.ext_cnt + 8'h01;

		// Live alarm flags
		next_s.status[S_NET_LOF]      = frm_lof[P_NET];
		next_s.status[S_NET_MF_LOSS]  = frm_mf_loss[P_NET] && cas;
		next_s.status[S_NET_CRC_LOSS] = frm_crc_loss[P_NET] && crc;
		next_s.status[S_NET_FAR]      = frm_nfas_bit3[P_NET];
		next_s.status[S_NET_FAR_MF]   = (s.mf_cnt[P_NET] == FAR_MF_COUNT);
		next_s.status[S_NET_AIS]      = frm_ais_det[P_NET];
		next_s.status[S_NET_TS16_AIS] = net_ts16_ais_det;
		next_s.status[S_LOOP1_DOWN]   = !loop1_present;
		next_s.status[S_LOOP2_DOWN]   = !loop2_present;
		next_s.status[S_DP_SLIP]      = dp_clock_slip;
		next_s.status[S_DP_PLL]       = dp_pll_unlocked;
		next_s.status[S_DP_ZEROS]     = (s.zero_run == ZERO_RUN_BITS);
		next_s.status[S_DP_FIFO]      = dp_fifo_error;
		next_s.status[S_DP_NO_EXT]    = s.ctrl[C_EXTERNAL_DTE_CLOCK_SELECT] && (s.ext_cnt == EXT_LAST);
		next_s.status[S_DROP_LOF]     = frm_lof[P_DROP];
		next_s.status[S_DROP_MF_LOSS] = frm_mf_loss[P_DROP] && cas;
		next_s.status[S_DROP_CRC]     = frm_crc_loss[P_DROP] && crc;
		next_s.status[S_DROP_LOS]     = drop_los_det;
		next_s.status[S_DROP_FAR]     = frm_nfas_bit3[P_DROP];
		next_s.status[S_DROP_FAR_MF]  = (s.mf_cnt[P_DROP] == FAR_MF_COUNT);
		next_s.status[S_DROP_AIS]     = frm_ais_det[P_DROP];
		next_s.status[S_DROP_SLIP]    = drop_slip;

		// Consequent actions from the registered flags
		next_s.net_remote = s.status[S_NET_LOF] || s.status[S_NET_CRC_LOSS];
		next_s.net_mf     = s.status[S_NET_MF_LOSS] || s.status[S_NET_TS16_AIS];
		next_s.d_ais      = s.status[S_NET_LOF] || s.status[S_NET_AIS]
			|| s.status[S_NET_CRC_LOSS] || s.status[S_DROP_CRC];
		next_s.d_ts16     = s.status[S_NET_MF_LOSS] || s.status[S_NET_TS16_AIS]
			|| s.status[S_DROP_MF_LOSS];
		next_s.d_remote   = s.status[S_DROP_LOF] || s.status[S_DROP_CRC];
		next_s.d_mf       = s.status[S_DROP_MF_LOSS];

		// Loopbacks
		next_s.loop_net  = s.ctrl[C_LOOP_UP];
		next_s.loop_dte  = s.ctrl[C_LOOP_UP];
		next_s.line_loop = s.ctrl[C_LINE_LOOP];
		next_s.port_loop = s.ctrl[C_PORT_LOOP];

		// Ones density: count clock cycles of continuous DTE zeros
		if (dte_tx_bit || !s.ctrl[C_ONES_DENS]) begin
			next_s.zero_cyc   = 24'h000000;
			next_s.force_ones = 1'b0;
		end else if (s.zero_cyc == SEC_LAST)
			next_s.force_ones = 1'b1;
		else
			next_s.zero_cyc = s.zero_cyc + 24'h000001;

		// Outgoing bit selection
		if (!s.ctrl[C_PATT_ON])
			next_s.prbs9 = PRBS9_SEED;
		if (!s.ctrl[C_REMOTE_LOOP])
			next_s.prbs7 = PRBS7_SEED;
		if (net_tx_strobe) begin
			case (src)
				SRC_PRBS: begin
					pat = prbs9_step(s.prbs9);
					next_s.prbs9 = pat;
					gen_bit = pat[0] ^ s.inject;
					next_s.inject = 1'b0;
				end
				SRC_V54: begin
					next_s.prbs7 = prbs7_step(s.prbs7);
					gen_bit = next_s.prbs7[0];
				end
				default:
					gen_bit = dte_tx_bit || s.force_ones;
			endcase
			next_s.tx_bit = gen_bit;
			if (gen_bit)
				next_s.zero_run = 5'h00;
			else if (s.zero_run != ZERO_RUN_BITS)
				next_s.zero_run = s.zero_run + 5'h01;
		end

		// Error injection request held until the next pattern bit
		if (wr && addr_hit(paddr, ADDR_INJECT) && pwdata[0])
			next_s.inject = 1'b1;

		// 511 checker, self-synchronising on the received stream
		if (net_rx_strobe) begin
			next_s.rx_hist = {s.rx_hist[7:0], net_rx_bit};
			rx_err = s.ctrl[C_PATT_ON] && (net_rx_bit != (s.rx_hist[8] ^ s.rx_hist[4]));
		end
		if (s.sec_cnt == SEC_LAST) begin
			next_s.sec_cnt = 24'h000000;
			next_s.sec_err = 1'b0;
			if (s.sec_err && s.errsec != 16'hFFFF)
				next_s.errsec = s.errsec + 16'h0001;
		end else
			next_s.sec_cnt = s.sec_cnt + 24'h000001;
		if (rx_err)
			next_s.sec_err = 1'b1;
		if (wr && addr_hit(paddr, ADDR_ERRSEC))
			next_s.errsec = 16'h0000;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s         <= '0;
			s.ctrl    <= CTRL_RST;
			s.prbs9   <= PRBS9_SEED;
			s.prbs7   <= PRBS7_SEED;
		end else
			s <= next_s;
	end

	assign prdata               = s.prdata;
	assign pready               = s.pready;
	assign pslverr              = s.pslverr;
	assign net_tx_bit           = s.tx_bit;
	assign net_tx_remote_alarm  = s.net_remote;
	assign net_tx_mf_alarm      = s.net_mf;
	assign drop_tx_ais          = s.d_ais;
	assign drop_tx_ts16_ais     = s.d_ts16;
	assign drop_tx_remote_alarm = s.d_remote;
	assign drop_tx_mf_alarm     = s.d_mf;
	assign dp_loop_net          = s.loop_net;
	assign dp_loop_dte          = s.loop_dte;
	assign drop_line_loop       = s.line_loop;
	assign drop_port_loop       = s.port_loop;

endmodule : eam_alarm

//--- tb/eam_alarm_assertions.sv
`timescale 1ns/1ps
module eam_alarm_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// APB answer
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// Causes
	input wire logic [1:0]  frm_lof,
	input wire logic [1:0]  frm_crc_loss,
	input wire logic [1:0]  frm_ais_det,
	input wire logic        net_ts16_ais_det,
	// Alarm outputs
	input wire logic        net_tx_remote_alarm,
	input wire logic        net_tx_mf_alarm,
	input wire logic        drop_tx_ais,
	input wire logic        drop_tx_ts16_ais,
	input wire logic        drop_tx_remote_alarm
);
	logic [2:0] up;
	logic       live;
	// Skips the internal reset synchroniser
	assign live = up == 3'h7;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			up <= 3'h0;
		else if (!live)
			up <= up + 3'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_apb_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero while idle");
	a_net_lof_out: assert property ((live && frm_lof[0]) [*3] |->
		net_tx_remote_alarm && drop_tx_ais)
		else $error("network frame loss not signalled");
	a_drop_lof_out: assert property ((live && frm_lof[1]) [*3] |-> drop_tx_remote_alarm)
		else $error("drop frame loss not signalled");
	a_net_ais_fwd: assert property ((live && frm_ais_det[0]) [*3] |-> drop_tx_ais)
		else $error("network AIS not forwarded");
	a_ts16_ais_fwd: assert property ((live && net_ts16_ais_det) [*3] |->
		net_tx_mf_alarm && drop_tx_ts16_ais)
		else $error("signalling slot AIS not forwarded");
	a_net_ra_quiet: assert property ((live && !frm_lof[0] && !frm_crc_loss[0]) [*3] |->
		!net_tx_remote_alarm)
		else $error("remote alarm without cause");
endmodule : eam_alarm_checker
bind eam_alarm eam_alarm_checker eam_alarm_checker_inst (.clk, .nrst, .psel, .penable,
	.pready, .pslverr, .prdata, .frm_lof, .frm_crc_loss, .frm_ais_det, .net_ts16_ais_det,
	.net_tx_remote_alarm, .net_tx_mf_alarm, .drop_tx_ais, .drop_tx_ts16_ais,
	.drop_tx_remote_alarm);

//--- tb/eam_line_model.sv
`timescale 1ns/1ps
module eam_line_model (
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Bench control and outgoing stream
	input wire logic       ext_run,
	input wire logic       tx_bit,
	// Line strobes and received stream
	output logic     [1:0] mf_strobe,
	output logic           bit_strobe,
	output logic           tx_strobe,
	output logic           rx_strobe,
	output logic           ext_edge,
	output logic           rx_bit
);
	logic [3:0] cnt;
	// Far end loops the outgoing stream straight back
	assign rx_bit = tx_bit;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{cnt, mf_strobe, bit_strobe, tx_strobe, rx_strobe, ext_edge} <= '0;
		end else begin
			cnt <= cnt + 4'h1;
			mf_strobe <= {2{cnt == 4'hF}};
			bit_strobe <= 1'b1;
			tx_strobe <= cnt[0];
			rx_strobe <= tx_strobe;
			ext_edge <= ext_run && cnt[1:0] == 2'h0;
		end
	end
endmodule : eam_line_model

//--- tb/eam_alarm_bench.sv
`timescale 1ns/1ps
module eam_alarm_bench;
	import eam_pkg::*;
	localparam int SEC = 50;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err, seen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0]  frm_lof, frm_mf_loss, frm_crc_loss, frm_mf_strobe, frm_ts16_bit6;
	logic [1:0]  frm_nfas_bit3, frm_ais_det, ra, ma;
	logic [10:0] lv;
	logic        net_ts16_ais_det, loop1_present, loop2_present, drop_los_det, drop_slip;
	logic        drop_bit_strobe, drop_bit_error, dp_clock_slip, dp_pll_unlocked;
	logic        dp_fifo_error, dte_external_dte_clock_select_edge, net_tx_strobe, dte_tx_bit, net_rx_strobe;
	logic        net_rx_bit, net_tx_bit, net_tx_remote_alarm, net_tx_mf_alarm, drop_tx_ais;
	logic        drop_tx_ts16_ais, drop_tx_remote_alarm, drop_tx_mf_alarm, dp_loop_net;
	logic        dp_loop_dte, drop_line_loop, drop_port_loop, ext_run;
	int          n_mismatch, compares;
	int          sb [11] = '{3, 5, 6, 9, 10, 12, 18, 20, 17, 7, 8};
	int          lb [4] = '{5, 6, 7, 8};
	logic [3:0]  le [4] = '{4'hC, 4'h0, 4'h2, 4'h1};
	assign {frm_nfas_bit3, frm_ais_det} = {lv[6], lv[0], lv[7], lv[1]};
	assign {net_ts16_ais_det, dp_clock_slip, dp_pll_unlocked} = {lv[2], lv[3], lv[4]};
	assign {dp_fifo_error, drop_los_det} = {lv[5], lv[8]};
	assign {loop2_present, loop1_present} = ~lv[10:9];
	assign ra = {drop_tx_remote_alarm, net_tx_remote_alarm};
	assign ma = {drop_tx_mf_alarm, net_tx_mf_alarm};
	eam_alarm #(.SEC_CYC(SEC)) eam_alarm_inst (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .frm_lof, .frm_mf_loss, .frm_crc_loss,
		.frm_nfas_bit3, .frm_mf_strobe, .frm_ts16_bit6, .frm_ais_det, .net_ts16_ais_det,
		.loop1_present, .loop2_present, .drop_los_det, .drop_slip, .drop_bit_strobe,
		.drop_bit_error, .dp_clock_slip, .dp_pll_unlocked, .dp_fifo_error, .dte_external_dte_clock_select_edge,
		.net_tx_strobe, .dte_tx_bit, .net_rx_strobe, .net_rx_bit, .net_tx_bit,
		.net_tx_remote_alarm, .net_tx_mf_alarm, .drop_tx_ais, .drop_tx_ts16_ais,
		.drop_tx_remote_alarm, .drop_tx_mf_alarm, .dp_loop_net, .dp_loop_dte,
		.drop_line_loop, .drop_port_loop);
	eam_line_model eam_line_model_inst (.clk, .nrst, .ext_run, .tx_bit(net_tx_bit),
		.mf_strobe(frm_mf_strobe), .bit_strobe(drop_bit_strobe), .tx_strobe(net_tx_strobe),
		.rx_strobe(net_rx_strobe), .ext_edge(dte_external_dte_clock_select_edge), .rx_bit(net_rx_bit));
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s exp %0h seen %0h", nm, e, s);
		end
	endtask : chk
	task automatic poll(input int b, input int n);
		seen = 1'b0;
		repeat (n) begin
			rd(ADDR_STATUS);
			seen = seen | q[b];
		end
	endtask : poll
	task automatic mfw;
		do @(posedge clk); while (frm_mf_strobe[0] !== 1'b1);
	endtask : mfw
	task automatic tally_and_finish;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#4000000;
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		{psel, penable, pwrite, drop_slip, drop_bit_error, ext_run, nrst} = '0;
		{paddr, pwdata, lv, frm_lof, frm_mf_loss, frm_crc_loss, frm_ts16_bit6} = '0;
		{dte_tx_bit, n_mismatch, compares} = {1'b1, 64'h0};
		wt(4);
		nrst <= 1'b1;
		wt(3);
		rd(ADDR_CTRL);
		chk("ctrl", q, {23'h0, CTRL_RST});
		rd(8'h14);
		chk("unmapped", {q[30:0], err}, 32'h1);
		$display("reset test done");
		for (int i = 0; i < 11; i++) begin
			lv <= 11'h1 << i;
			wt(3);
			rd(ADDR_STATUS);
			chk("flag", q, 32'h1 << sb[i]);
		end
		lv <= 11'h0;
		wt(3);
		rd(ADDR_STATUS);
		chk("clear", q, 32'h0);
		$display("flag test done");
		for (int p = 0; p < 2; p++) begin
			frm_lof[p] <= 1'b1;
			wt(4);
			chk("lof", {ra[p], drop_tx_ais}, {1'b1, p == 0});
			frm_lof <= 2'h0;
			frm_mf_loss[p] <= 1'b1;
			wt(4);
			chk("mf off", {ma[p], drop_tx_ts16_ais}, 32'h0);
			wr(ADDR_CTRL, 32'h1);
			wt(3);
			chk("mf on", {ma[p], drop_tx_ts16_ais}, 32'h3);
			wr(ADDR_CTRL, 32'h0);
			frm_mf_loss <= 2'h0;
			frm_crc_loss[p] <= 1'b1;
			wt(4);
			chk("crc off", {ra[p], drop_tx_ais}, 32'h0);
			wr(ADDR_CTRL, 32'h2);
			wt(3);
			chk("crc on", {ra[p], drop_tx_ais}, 32'h3);
			wr(ADDR_CTRL, 32'h0);
			frm_crc_loss <= 2'h0;
			wt(4);
			chk("idle", {ra, ma, drop_tx_ais, drop_tx_ts16_ais}, 32'h0);
		end
		$display("gating test done");
		frm_ts16_bit6 <= 2'h3;
		mfw;
		mfw;
		wt(2);
		rd(ADDR_STATUS);
		chk("mf two", {q[19], q[4]}, 32'h0);
		mfw;
		wt(3);
		rd(ADDR_STATUS);
		chk("mf three", {q[19], q[4]}, 32'h3);
		frm_ts16_bit6 <= 2'h0;
		mfw;
		wt(3);
		rd(ADDR_STATUS);
		chk("mf end", {q[19], q[4]}, 32'h0);
		drop_slip <= 1'b1;
		wt(1);
		drop_slip <= 1'b0;
		wt(3);
		rd(ADDR_HIST);
		chk("hist", q, 32'h1);
		rd(ADDR_STATUS);
		chk("slip live", q[22], 32'h0);
		wr(ADDR_HIST, 32'h1);
		rd(ADDR_HIST);
		chk("hist clr", q, 32'h0);
		$display("multiframe and slip test done");
		drop_bit_error <= 1'b1;
		wt(1);
		drop_bit_error <= 1'b0;
		poll(21, 600);
		chk("ber one", seen, 32'h0);
		drop_bit_error <= 1'b1;
		wt(4);
		drop_bit_error <= 1'b0;
		poll(21, 600);
		chk("ber four", seen, 32'h1);
		poll(13, 80);
		chk("ext int", seen, 32'h0);
		wr(ADDR_CTRL, 32'h4);
		poll(13, 80);
		chk("ext miss", seen, 32'h1);
		ext_run <= 1'b1;
		wt(10);
		rd(ADDR_STATUS);
		chk("ext ok", q[13], 32'h0);
		$display("ratio and clock test done");
		wr(ADDR_CTRL, 32'h10);
		dte_tx_bit <= 1'b0;
		wt(100);
		wr(ADDR_ERRSEC, 32'h0);
		wt(300);
		rd(ADDR_ERRSEC);
		chk("es clean", q, 32'h0);
		rd(ADDR_STATUS);
		chk("no zeros", q[11], 32'h0);
		wr(ADDR_INJECT, 32'h1);
		wt(200);
		rd(ADDR_ERRSEC);
		chk("es inject", q != 32'h0, 32'h1);
		wr(ADDR_CTRL, 32'h0);
		wt(50);
		rd(ADDR_STATUS);
		chk("zeros", {q[11], net_tx_bit}, 32'h2);
		dte_tx_bit <= 1'b1;
		wt(10);
		wr(ADDR_CTRL, 32'h8);
		dte_tx_bit <= 1'b0;
		wt(SEC - 4);
		chk("od early", net_tx_bit, 32'h0);
		wt(8);
		chk("od force", net_tx_bit, 32'h1);
		$display("stream test done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, 32'h1 << lb[i]);
			wt(2);
			chk("loops", {dp_loop_net, dp_loop_dte, drop_line_loop, drop_port_loop}, le[i]);
			if (i == 1) begin
				q = 32'h0;
				repeat (20) begin
					wt(1);
					q[net_tx_bit] = 1'b1;
				end
				chk("v54", q, 32'h3);
			end
		end
		rd(ADDR_CTRL);
		chk("ctrl rw", q, 32'h100);
		wr(ADDR_CTRL, 32'h0);
		wt(2);
		chk("loop down", {dp_loop_net, dp_loop_dte, drop_line_loop, drop_port_loop}, 32'h0);
		$display("loop test done");
		tally_and_finish;
	end
endmodule : eam_alarm_bench
